// File: design/clut_pkg.sv
// Package of offsets, field positions and encodings for the color look-up table
package clut_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_ENTRY_WRITE = 8'h18;
  localparam logic [7:0] OFF_ENTRY_READ = 8'h1c;
  localparam logic [7:0] OFF_MODE = 8'h20;
  // Field positions in the palette registers
  localparam int IDX_LSB = 24;
  localparam int RED_LSB = 18;
  localparam int GRN_LSB = 10;
  localparam int BLU_LSB = 2;
  localparam int COMP_W = 6;
  localparam int IDX_W = 8;
  // Mode register field positions
  localparam int MODE_BPP_LSB = 0;
  localparam int MODE_COLOR_BIT = 4;
  // Reset values
  localparam logic [31:0] ENTRY_WRITE_RESET = 32'h0000_0000;
  localparam logic [2:0] MODE_BPP_RESET = 3'h0;
  // Color depth encodings
  localparam logic [2:0] BPP_1 = 3'h0;
  localparam logic [2:0] BPP_2 = 3'h1;
  localparam logic [2:0] BPP_4 = 3'h2;
  localparam logic [2:0] BPP_8 = 3'h3;
  localparam logic [2:0] BPP_16 = 3'h4;
  // 5-6-5 pixel field positions
  localparam int P16_RED_LSB = 11;
  localparam int P16_GRN_LSB = 5;
  localparam int P16_BLU_LSB = 0;
endpackage : clut_pkg

// File: design/color_lookup_table_palette.sv
// Color look-up table with APB register access and pixel-to-intensity mapping
//
// Overview of operation
// - 16 bpp splits pixel as 5-6-5
// - 16 bpp color bypasses the table
// - 16 bpp mono sends six green bits
// - 256 entries, six-bit red green blue
// - Depth limits usable low palette indices
// - Color uses entry, mono uses green
// - Write register fields index red green blue
// - Commit only when index lane written, lane 0 instead with BIG_ENDIAN
// - Write register reads as zero
// - Read register index in, components out
// - Set read index, then read entry
// - Read index field returns zero
// - Write register staging resets to zero
// - Mono output uses only green component
// - 8 bpp mono gives 64 levels
`timescale 1ns/1ps
`default_nettype none
module color_lookup_table_palette #(
  parameter int ENTRIES = 256, // Palette depth
  parameter bit BIG_ENDIAN = 1'b0 // Selects lane 0 or lane 3 as the strobe that commits; the index stays in bits 31:24
) (
  input wire logic pclk, // Register clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic pix_valid, // Pixel strobe from the fetch logic
  input wire logic [15:0] pix_data, // Pixel value, right aligned
  output logic out_valid, // Output strobe to the modulator
  output logic [5:0] out_red, // Red intensity
  output logic [5:0] out_green, // Green or gray intensity
  output logic [5:0] out_blue, // Blue intensity
  output logic [2:0] mode_bpp, // Current color depth
  output logic mode_color // Color panel when high
);
  // Palette storage, one word per component set
  logic [17:0] palette [ENTRIES];
  // Staged write register contents
  logic [31:0] wr_stage;
  // Read index pointer
  logic [7:0] rd_index;
  // Entry view for the read register
  logic [17:0] rd_entry;

  // Bus decode
  wire access = psel & penable;
  wire wr_en = access & pwrite;
  wire hit_write = (paddr == clut_pkg::OFF_ENTRY_WRITE);
  wire hit_read = (paddr == clut_pkg::OFF_ENTRY_READ);
  wire hit_mode = (paddr == clut_pkg::OFF_MODE);
  wire unmapped = ~(hit_write | hit_read | hit_mode);
  // Lane whose strobe commits depends on host byte order; the index stays in the top byte
  wire index_lane = BIG_ENDIAN ? pstrb[0] : pstrb[3];
  wire commit = wr_en & hit_write & index_lane;
  // Staged value after merging this write's byte lanes
  logic [31:0] next_stage;
  always_comb begin
    // Partial writes only touch strobed bytes
    for (int b = 0; b < 4; b++) begin
      next_stage[b*8 +: 8] = pstrb[b] ? pwdata[b*8 +: 8] : wr_stage[b*8 +: 8];
    end
  end
  // Index and components from the merged value, so a full write commits at once
  wire [7:0] stage_idx = next_stage[clut_pkg::IDX_LSB +: clut_pkg::IDX_W];
  wire [17:0] stage_rgb = {next_stage[clut_pkg::RED_LSB +: clut_pkg::COMP_W],
                           next_stage[clut_pkg::GRN_LSB +: clut_pkg::COMP_W],
                           next_stage[clut_pkg::BLU_LSB +: clut_pkg::COMP_W]};

  // Slave always answers in the access cycle
  assign pready = 1'b1;
  assign pslverr = access & unmapped;

  // Staging register for the palette write register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_stage <= clut_pkg::ENTRY_WRITE_RESET;
    end else if (wr_en && hit_write) begin
      wr_stage <= next_stage;
    end
  end

  // Read index pointer, written through the top byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_index <= 8'h00;
    end else if (wr_en && hit_read && pstrb[3]) begin
      rd_index <= pwdata[clut_pkg::IDX_LSB +: clut_pkg::IDX_W];
    end
  end

  // Mode register: depth and color/mono select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_bpp <= clut_pkg::MODE_BPP_RESET;
      mode_color <= 1'b0;
    end else if (wr_en && hit_mode && pstrb[0]) begin
      mode_bpp <= pwdata[clut_pkg::MODE_BPP_LSB +: 3];
      mode_color <= pwdata[clut_pkg::MODE_COLOR_BIT];
    end
  end

  // Palette array write; no reset, contents are loaded by software
  always_ff @(posedge pclk) begin
    if (commit) begin
      palette[stage_idx] <= stage_rgb;
    end
  end

  // Read path looks at the array directly, so a prior commit is visible
  assign rd_entry = palette[rd_index];
  logic [31:0] rd_word;
  always_comb begin
    // Index field and unused bits stay zero
    rd_word = 32'h0000_0000;
    rd_word[clut_pkg::RED_LSB +: clut_pkg::COMP_W] = rd_entry[17:12];
    rd_word[clut_pkg::GRN_LSB +: clut_pkg::COMP_W] = rd_entry[11:6];
    rd_word[clut_pkg::BLU_LSB +: clut_pkg::COMP_W] = rd_entry[5:0];
  end
  wire [31:0] mode_word = {27'h000_0000, mode_color, 1'b0, mode_bpp};
  // Write register is write-only and returns zero
  wire [31:0] next_rdata = hit_read ? rd_word :
                           hit_mode ? mode_word : 32'h0000_0000;

  // Read data registered only in the setup cycle of a read, before penable rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  // Depth masks the index so only the low entries are reachable
  logic [7:0] pix_index;
  always_comb begin
    unique case (mode_bpp)
      clut_pkg::BPP_1: pix_index = {7'h00, pix_data[0]};
      clut_pkg::BPP_2: pix_index = {6'h00, pix_data[1:0]};
      clut_pkg::BPP_4: pix_index = {4'h0, pix_data[3:0]};
      default: pix_index = pix_data[7:0];
    endcase
  end
  wire is16 = (mode_bpp == clut_pkg::BPP_16);
  wire [17:0] pix_entry = palette[pix_index];
  // 5-6-5 split, five-bit fields widened by their top bit into six
  wire [4:0] p_red = pix_data[clut_pkg::P16_RED_LSB +: 5];
  wire [5:0] p_grn = pix_data[clut_pkg::P16_GRN_LSB +: 6];
  wire [4:0] p_blu = pix_data[clut_pkg::P16_BLU_LSB +: 5];
  // Mono at 8 bpp: green alone gives 64 levels, entries beyond alias by value
  wire [5:0] next_green = is16 ? p_grn : pix_entry[11:6];
  wire [5:0] next_red = !mode_color ? next_green : is16 ? {p_red, p_red[4]} : pix_entry[17:12];
  wire [5:0] next_blue = !mode_color ? next_green : is16 ? {p_blu, p_blu[4]} : pix_entry[5:0];

  // Output stage, one cycle after the pixel strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_red <= 6'h00;
      out_green <= 6'h00;
      out_blue <= 6'h00;
    end else begin
      out_valid <= pix_valid;
      if (pix_valid) begin
        out_red <= next_red;
        out_green <= next_green;
        out_blue <= next_blue;
      end
    end
  end

  // Assertions
  property p_commit_lands;
    @(posedge pclk) disable iff (!presetn)
      commit |=> palette[$past(stage_idx)] == $past(stage_rgb);
  endproperty
  a_commit_lands: assert property (p_commit_lands) else $error("palette commit lost");
  property p_write_reads_zero;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_write) |=> prdata == 32'h0000_0000;
  endproperty
  a_write_reads_zero: assert property (p_write_reads_zero) else $error("write register read nonzero");
  property p_read_unused_zero;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_read) |=> (prdata & 32'hff03_0303) == 32'h0000_0000;
  endproperty
  a_read_unused_zero: assert property (p_read_unused_zero) else $error("read register unused bits set");
  property p_mono_gray;
    @(posedge pclk) disable iff (!presetn)
      (out_valid && !$past(mode_color)) |-> (out_red == out_green && out_blue == out_green);
  endproperty
  a_mono_gray: assert property (p_mono_gray) else $error("mono output not gray");
  property p_bypass_green;
    @(posedge pclk) disable iff (!presetn)
      (pix_valid && is16) |=> out_green == $past(pix_data[10:5]);
  endproperty
  a_bypass_green: assert property (p_bypass_green) else $error("16 bpp green not passed");
  // Mono at 16 bpp: all three outputs carry the six pixel green bits
  property p_mono16_green;
    @(posedge pclk) disable iff (!presetn)
      (pix_valid && is16 && !mode_color) |=> (out_red == $past(pix_data[10:5]) && out_blue == $past(pix_data[10:5]));
  endproperty
  a_mono16_green: assert property (p_mono16_green) else $error("16 bpp mono gray not from green bits");
  // One bpp may only ever reach the first two entries
  property p_depth_mask;
    @(posedge pclk) disable iff (!presetn)
      (mode_bpp == clut_pkg::BPP_1) |-> (pix_index[7:1] == 7'h00);
  endproperty
  a_depth_mask: assert property (p_depth_mask) else $error("1 bpp index beyond first two entries");
  // Output strobe follows the pixel strobe by exactly one cycle
  property p_out_latency;
    @(posedge pclk) disable iff (!presetn)
      pix_valid |=> out_valid;
  endproperty
  a_out_latency: assert property (p_out_latency) else $error("pixel result strobe missing");
endmodule : color_lookup_table_palette
`default_nettype wire

// File: bench/color_lookup_table_palette_tb.sv
// Self-checking bench for the color look-up table
`timescale 1ns/1ps
`default_nettype none
module color_lookup_table_palette_tb;
  logic pclk, presetn, psel, penable, pwrite, pix_valid; // Driven inputs
  logic [7:0] paddr; // Byte address
  logic [31:0] pwdata, prdata, seed; // Bus data and seed
  logic [3:0] pstrb; // Byte strobes
  logic pready, pslverr, out_valid, mode_color; // Design outputs
  logic [5:0] out_red, out_green, out_blue; // Intensities
  logic [2:0] mode_bpp; // Depth copy
  logic [15:0] pix_data; // Pixel value
  logic [17:0] pal [256]; // Bench copy of the palette
  logic [32:0] rq [$]; // Expected error flag and read data
  logic [17:0] pq [$]; // Expected pixel intensities
  int err_count, compares; // Tallies
  color_lookup_table_palette color_lookup_table_palette_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pix_valid(pix_valid), .pix_data(pix_data), .out_valid(out_valid),
    .out_red(out_red), .out_green(out_green), .out_blue(out_blue), .mode_bpp(mode_bpp), .mode_color(mode_color));
  // Clock, 50 ns period
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Mismatch report
  task check(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Verdict and end of run
  task wrap_up;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // One APB transfer; a read notes its expected answer first
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [32:0] e);
    if (!w) rq.push_back(e);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Register image of an entry, unused bits zero
  function automatic logic [31:0] ent(input logic [7:0] i, input logic [17:0] c);
    return {i, c[17:12], 2'b00, c[11:6], 2'b00, c[5:0], 2'b00};
  endfunction : ent
  // Set read index, then read the entry back
  task rd(input logic [7:0] i);
    apb(1'b1, clut_pkg::OFF_ENTRY_READ, {i, 24'h00_0000}, 4'h8, 33'h0);
    apb(1'b0, clut_pkg::OFF_ENTRY_READ, 32'h0, 4'h0, {1'b0, ent(8'h00, pal[i])});
  endtask : rd
  // Expected output of one pixel; mono keeps only green
  function automatic logic [17:0] px(input logic [2:0] b, input logic c, input logic [15:0] p);
    logic [7:0] i;
    logic [17:0] e;
    i = b == clut_pkg::BPP_1 ? {7'h00, p[0]} : b == clut_pkg::BPP_2 ? {6'h00, p[1:0]} :
      b == clut_pkg::BPP_4 ? {4'h0, p[3:0]} : p[7:0];
    e = b == clut_pkg::BPP_16 ? {p[15:11], p[15], p[10:5], p[4:0], p[4]} : pal[i];
    if (!c) e = {3{e[11:6]}};
    return e;
  endfunction : px
  // Result watcher: oldest note against each answer
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) check({pslverr, prdata}, rq.pop_front());
    if (out_valid === 1'b1) check({15'h0000, out_red, out_green, out_blue}, {15'h0000, pq.pop_front()});
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [15:0] p;
    seed = 32'h21e6_668b;
    {psel, penable, pwrite, pix_valid, paddr, pwdata, pstrb, pix_data} = '0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, clut_pkg::OFF_ENTRY_WRITE, 32'h0, 4'h0, 33'h0);
    apb(1'b0, 8'h40, 32'h0, 4'h0, {1'b1, 32'h0000_0000}); // Unmapped place refused
    // Fill all entries, junk in the unused bits
    for (int i = 0; i < 256; i++) begin
      pal[i] = 18'($random(seed));
      d = $random(seed);
      apb(1'b1, clut_pkg::OFF_ENTRY_WRITE, ent(i[7:0], pal[i]) | (d & 32'h0003_0303), 4'hf, 33'h0);
    end
    for (int i = 0; i < 256; i += 51) rd(i[7:0]);
    // Colors first, index lane last; commit only on the index lane
    d = $random(seed);
    apb(1'b1, clut_pkg::OFF_ENTRY_WRITE, ent(8'h05, d[17:0]), 4'h7, 33'h0);
    rd(8'h05);
    apb(1'b1, clut_pkg::OFF_ENTRY_WRITE, 32'h0500_0000, 4'h8, 33'h0);
    pal[5] = d[17:0];
    rd(8'h05);
    // Every depth in color and mono, random pixels back to back
    for (int m = 0; m < 10; m++) begin
      apb(1'b1, clut_pkg::OFF_MODE, (32'(m % 2) << clut_pkg::MODE_COLOR_BIT) | 32'(m / 2), 4'hf, 33'h0);
      apb(1'b0, clut_pkg::OFF_MODE, 32'h0, 4'h0, {1'b0, (32'(m % 2) << clut_pkg::MODE_COLOR_BIT) | 32'(m / 2)});
      check({29'h0000_0000, mode_color, mode_bpp}, {29'h0000_0000, m[0], 3'(m / 2)});
      for (int k = 0; k < 8; k++) begin
        p = 16'($random(seed));
        pq.push_back(px(3'(m / 2), m[0], p));
        pix_valid <= 1'b1;
        pix_data <= p;
        @(posedge pclk);
      end
      pix_valid <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    wrap_up();
  end
endmodule : color_lookup_table_palette_tb
`default_nettype wire
